// ### logic/jrm_defs.svh
// Purpose: shared constants of the test reset and mode latch link
// Assumes: one system clock of 250 MHz on both ends
// Notes: timing figures kept in ns, cycle counts derived from them
`ifndef JRM_DEFS_SVH
`define JRM_DEFS_SVH

`define JRM_CLK_NS 4
`define JRM_TCK_MIN_NS 50
`define JRM_TCK_HALF_CYC \
    ((`JRM_TCK_MIN_NS / 2 + `JRM_CLK_NS - 1) / `JRM_CLK_NS)
`define JRM_RST_TCKS 5
`define JRM_ID_ADDR 32'h01c40028
`define JRM_ID_REV_MSB 31
`define JRM_ID_REV_LSB 28
`define JRM_MODE_BSCAN_CODE 2'h3
`define JRM_SYNC_RST 7'h00

`endif

// ### logic/jrm_pkg.sv
// Purpose: types of the test reset and mode latch link
// Assumes: nothing beyond the defs header
// Notes: encodings written out
package jrm_pkg;

    typedef enum logic {
        JRM_EMU = 1'b0,
        JRM_BSCAN = 1'b1
    } jrm_mode_t;

    typedef enum logic [1:0] {
        JRM_ST_HOLD = 2'b00,
        JRM_ST_TEST_RST = 2'b01,
        JRM_ST_RUN = 2'b10
    } jrm_ctl_state_t;

endpackage : jrm_pkg

// ### logic/jrm_if.sv
// Purpose: pins between the test controller and the device
// Assumes: the controller makes the test clock
// Notes: test reset is resolved here with a weak pull to low
`timescale 1ns/10ps
interface jrm_if;
    logic sys_rst_n;
    logic tck;
    logic trst_n_o;
    logic trst_n_oe;
    logic trst_n;
    logic [1:0] mode_select_pins;
    logic tms;
    logic tdi;
    logic tdo;

    // undriven pin reads as asserted
    assign trst_n = trst_n_oe ? trst_n_o : 1'b0;

    modport dev (
        input sys_rst_n,
        input tck,
        input trst_n,
        input mode_select_pins,
        input tms,
        input tdi,
        output tdo
    );

    modport ctl (
        output sys_rst_n,
        output tck,
        output trst_n_o,
        output trst_n_oe,
        output mode_select_pins,
        output tms,
        output tdi,
        input tdo
    );
endinterface : jrm_if

// ### logic/jrm_ctl.sv
// Purpose: controller end, drives resets, test clock and mode pins
// Assumes: i_clk at 250 MHz, test clock made by a divider
// Notes: always drives test reset actively, high and low
`timescale 1ns/10ps
`include "jrm_defs.svh"
module jrm_ctl #(
    parameter logic [7:0] HALF = 8'(`JRM_TCK_HALF_CYC),
    parameter logic [7:0] RST_TCKS = 8'(`JRM_RST_TCKS)
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    jrm_if.ctl link,
    input wire logic i_sys_hold,
    input wire logic i_debug_en,
    input wire logic [1:0] i_mode,
    input wire logic i_tms,
    input wire logic i_tdi,
    output logic o_tdo,
    output logic o_tdo_valid,
    output logic o_trst_released
);
    import jrm_pkg::*;

    logic [7:0] div_cnt;
    logic tck_q;
    logic [7:0] edge_cnt;
    jrm_ctl_state_t state;
    jrm_ctl_state_t next_state;
    logic sys_rst_n_q;
    logic trst_n_q;
    logic [1:0] mode_q;
    logic tms_q;
    logic tdi_q;
    logic [2:0] tdo_s;
    logic tdo_f;

    wire div_end = (div_cnt == HALF - 8'h01);
    wire tck_rise = div_end & ~tck_q;
    wire tck_fall = div_end & tck_q;
    wire held_enough = (edge_cnt >= RST_TCKS);
    wire tdo_agree = ~(tdo_s[1] ^ tdo_s[2]);
    wire next_tdo_f = tdo_agree ? tdo_s[2] : tdo_f;

    always_comb begin
        next_state = state;
        unique case (state)
            // both resets held from power up until clocked enough
            JRM_ST_HOLD: if (tck_fall && held_enough) begin
                next_state = JRM_ST_TEST_RST;
            end
            // release test reset only when debug is wanted
            JRM_ST_TEST_RST: if (tck_fall && i_debug_en) begin
                next_state = JRM_ST_RUN;
            end
            JRM_ST_RUN: if (tck_fall && !i_debug_en) begin
                next_state = JRM_ST_TEST_RST;
            end
            default: next_state = JRM_ST_HOLD;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            div_cnt <= 8'h00;
            tck_q <= 1'b0;
        end else if (i_ce) begin
            div_cnt <= div_end ? 8'h00 : div_cnt + 8'h01;
            tck_q <= tck_q ^ div_end;
        end
    end

    // edges counted while test reset is low
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            edge_cnt <= 8'h00;
        end else if (i_ce) begin
            if (state == JRM_ST_RUN) begin
                edge_cnt <= 8'h00;
            end else if (tck_rise && !held_enough) begin
                edge_cnt <= edge_cnt + 8'h01;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state <= JRM_ST_HOLD;
            sys_rst_n_q <= 1'b0;
            trst_n_q <= 1'b0;
            mode_q <= 2'h0;
        end else if (i_ce) begin
            state <= next_state;
            sys_rst_n_q <= (next_state != JRM_ST_HOLD) && !i_sys_hold;
            trst_n_q <= (next_state == JRM_ST_RUN);
            mode_q <= i_mode;
        end
    end

    // scan pins only move in run, on the falling test clock
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tms_q <= 1'b0;
            tdi_q <= 1'b0;
        end else if (i_ce && tck_fall) begin
            tms_q <= (next_state == JRM_ST_RUN) & i_tms;
            tdi_q <= (next_state == JRM_ST_RUN) & i_tdi;
        end
    end

    // tdo sampled a full period late: the device answers slowly
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tdo_s <= 3'h0;
            tdo_f <= 1'b0;
            o_tdo <= 1'b0;
            o_tdo_valid <= 1'b0;
            o_trst_released <= 1'b0;
        end else if (i_ce) begin
            tdo_s <= {tdo_s[1:0], link.tdo};
            tdo_f <= next_tdo_f;
            o_tdo_valid <= tck_fall && (state == JRM_ST_RUN);
            if (tck_fall) begin
                o_tdo <= tdo_f;
            end
            o_trst_released <= trst_n_q;
        end
    end

    assign link.tck = tck_q;
    assign link.sys_rst_n = sys_rst_n_q;
    assign link.trst_n_o = trst_n_q;
    assign link.trst_n_oe = 1'b1;
    assign link.mode_select_pins = mode_q;
    assign link.tms = tms_q;
    assign link.tdi = tdi_q;

endmodule : jrm_ctl

// ### logic/jrm_dev.sv
// Purpose: device end, test reset handling, mode latch, id register
// Assumes: every link pin is asynchronous to i_clk
// Notes: scan chain is a minimal id/bypass path, not a full tap
`timescale 1ns/10ps
`include "jrm_defs.svh"

// What this block does
// - outside asserts both resets at power up
// - device runs once system reset releases
// - low test reset holds test logic reset
// - controller releases test reset only to debug
// - test reset acts only on test clock edges
// - revision digit valid after system reset release
// - bypass works whatever system reset is
// - test reset pin pulled low internally
// - scan activity only after test reset high
// - latch mode pins on test reset rise, once system reset has released
// - latched value picks scan or emulation mode
// - read-only 32-bit id at fixed address
// - top hex digit revision, rest fixed
module jrm_dev #(
    // arbitrary identification values
    parameter logic [3:0] ID_REV = 4'h1,
    parameter logic [27:0] ID_FIXED = 28'h5a3c001
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    jrm_if.dev link,
    input wire logic i_rd,
    input wire logic i_wr,
    input wire logic [31:0] i_addr,
    output logic [31:0] o_rdata,
    output logic o_rvalid,
    output logic o_sys_run,
    output logic o_test_rst,
    output jrm_pkg::jrm_mode_t o_mode,
    output logic o_mode_valid
);
    import jrm_pkg::*;

    // pin vector order: sys_rst_n, tck, trst_n, mode[1:0], tms, tdi
    localparam int PW = 7;

    logic [PW-1:0] s1;
    logic [PW-1:0] s2;
    logic [PW-1:0] s3;
    logic [PW-1:0] flt;
    logic tck_prev;
    logic trst_seen;
    logic sys_up;
    logic test_rst;
    jrm_mode_t mode;
    logic mode_valid;
    logic [31:0] id_sh;
    logic byp;
    logic tdo_q;

    // revision reads zero until the system side is up
    function automatic logic [31:0] id_value(input logic up);
        logic [3:0] rev;
        rev = up ? ID_REV : 4'h0;
        return {rev, ID_FIXED};
    endfunction : id_value

    wire [PW-1:0] pins = {link.sys_rst_n, link.tck, link.trst_n,
                          link.mode_select_pins, link.tms, link.tdi};
    wire [PW-1:0] agree = ~(s2 ^ s3);
    wire [PW-1:0] next_flt = (s3 & agree) | (flt & ~agree);

    wire f_sys = flt[6];
    wire f_tck = flt[5];
    // an undriven test reset already reads low at the pin
    wire f_trst = flt[4];
    wire [1:0] f_mode = flt[3:2];
    wire f_tms = flt[1];
    wire f_tdi = flt[0];

    wire tck_rise = f_tck & ~tck_prev;
    wire tck_fall = ~f_tck & tck_prev;
    // rising test reset, seen on a test clock edge
    wire trst_rise = tck_rise & f_trst & ~trst_seen;
    wire latch_now = trst_rise & sys_up;

    // only the all-ones code picks boundary scan, else emulation
    wire [1:0] mode_code = `JRM_MODE_BSCAN_CODE;
    wire is_bscan = (f_mode == mode_code);
    wire jrm_mode_t next_mode = is_bscan ? JRM_BSCAN : JRM_EMU;

    // a single decoded word; other addresses read back zero
    wire id_hit = (i_addr == `JRM_ID_ADDR);
    wire [31:0] next_rdata = (i_rd && id_hit) ? id_value(sys_up) : 32'h0;

    // chain and bypass held at zero while test reset holds
    wire shift_en = tck_rise & ~test_rst;
    // scan mode shows the id chain, emulation a bypass bit
    wire next_tdo = (mode == JRM_BSCAN) ? id_sh[0] : byp;

    // three-stage pin sampling, change taken when last two agree
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s1 <= `JRM_SYNC_RST;
            s2 <= `JRM_SYNC_RST;
            s3 <= `JRM_SYNC_RST;
            flt <= `JRM_SYNC_RST;
            tck_prev <= 1'b0;
        end else if (i_ce) begin
            s1 <= pins;
            s2 <= s1;
            s3 <= s2;
            flt <= next_flt;
            tck_prev <= f_tck;
        end
    end

    // system side follows its reset alone, test reset ignored
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sys_up <= 1'b0;
        end else if (i_ce) begin
            sys_up <= f_sys;
        end
    end

    // test reset level only taken at a test clock edge
    // trst_seen keeps one rise from latching twice
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            test_rst <= 1'b1;
            trst_seen <= 1'b0;
        end else if (i_ce && tck_rise) begin
            test_rst <= ~f_trst;
            trst_seen <= f_trst;
        end
    end

    // mode only moves on a qualified rise, pins ignored otherwise
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            mode <= JRM_EMU;
            mode_valid <= 1'b0;
        end else if (i_ce && latch_now) begin
            mode <= next_mode;
            mode_valid <= 1'b1;
        end
    end

    // id chain: tms high loads, low shifts lsb first
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            id_sh <= 32'h0;
            byp <= 1'b0;
        end else if (i_ce) begin
            if (test_rst) begin
                id_sh <= 32'h0;
                byp <= 1'b0;
            end else if (shift_en) begin
                if (f_tms) begin
                    id_sh <= id_value(sys_up);
                end else begin
                    id_sh <= {f_tdi, id_sh[31:1]};
                end
                byp <= f_tdi;
            end
        end
    end

    // tdo moves on the falling test clock
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tdo_q <= 1'b0;
        end else if (i_ce) begin
            if (test_rst) begin
                tdo_q <= 1'b0;
            end else if (tck_fall) begin
                tdo_q <= next_tdo;
            end
        end
    end

    // register read port; nothing is stored, but a write drops the read valid
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rdata <= 32'h0;
            o_rvalid <= 1'b0;
        end else if (i_ce) begin
            o_rdata <= next_rdata;
            o_rvalid <= i_rd & ~i_wr;
        end
    end

    // status outputs registered so they come from flops
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_sys_run <= 1'b0;
            o_test_rst <= 1'b1;
            o_mode <= JRM_EMU;
            o_mode_valid <= 1'b0;
        end else if (i_ce) begin
            o_sys_run <= sys_up;
            o_test_rst <= test_rst;
            o_mode <= mode;
            o_mode_valid <= mode_valid;
        end
    end

    assign link.tdo = tdo_q;

endmodule : jrm_dev

// ### verification/jrm_checker.sv
// Purpose: assertions on the link pins between the two ends
// Assumes: pins sampled on the device clock
// Notes: long counts kept in helper counters
`timescale 1ns/10ps
module jrm_checker #(
    parameter logic [7:0] HALF = 8'h07,
    parameter logic [7:0] RST_TCKS = 8'h05
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic sys_rst_n,
    input wire logic tck,
    input wire logic trst_n_o,
    input wire logic trst_n_oe,
    input wire logic trst_n,
    input wire logic [1:0] mode_select_pins,
    input wire logic tms,
    input wire logic tdi,
    input wire logic tdo
);
    logic tck_q;
    logic [7:0] hold_rises;
    logic [7:0] half_cnt;
    logic [7:0] low_cnt;
    wire tck_rise = tck && !tck_q;
    wire both_low = !sys_rst_n && !trst_n;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    // half_cnt stays 0 until the first edge, so reset phase is skipped
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tck_q <= 1'b0;
            hold_rises <= 8'h00;
            half_cnt <= 8'h00;
            low_cnt <= 8'h00;
        end else begin
            tck_q <= tck;
            if (tck_rise && both_low && hold_rises != 8'hff)
                hold_rises <= hold_rises + 8'h01;
            if (tck != tck_q)
                half_cnt <= 8'h01;
            else if (half_cnt != 8'h00 && half_cnt != 8'hff)
                half_cnt <= half_cnt + 8'h01;
            if (trst_n)
                low_cnt <= 8'h00;
            else if (low_cnt != 8'hff)
                low_cnt <= low_cnt + 8'h01;
        end
    end

    pull_low_a: assert property (
        trst_n == (trst_n_oe && trst_n_o))
        else $error("test reset level not resolved low");
    hold_tcks_a: assert property (
        $rose(sys_rst_n) |-> hold_rises >= RST_TCKS)
        else $error("system reset left before clocked hold");
    trst_tcks_a: assert property (
        $rose(trst_n) |-> hold_rises >= RST_TCKS)
        else $error("test reset left before clocked hold");
    trst_sync_a: assert property (
        $rose(trst_n) |-> !tck)
        else $error("test reset released off the clock fall");
    tck_half_a: assert property (
        (tck != tck_q) && (half_cnt != 8'h00) |-> half_cnt == HALF)
        else $error("test clock half period wrong");
    scan_quiet_a: assert property (
        !trst_n [*2] |-> !tms && !tdi)
        else $error("scan lines active in test reset");
    tdo_reset_a: assert property (
        low_cnt >= 8'd24 |-> !tdo)
        else $error("tdo not held in test reset");
    tdo_edge_a: assert property (
        $changed(tdo) && trst_n |-> !tck)
        else $error("tdo changed while test clock high");
endmodule : jrm_checker

// ### verification/tb_top.sv
// Purpose: self-checking bench joining controller and device ends
// Assumes: the controller divides its own test clock
// Notes: waits count test clock rises plus sync margin
`timescale 1ns/10ps
module tb_top;
    import jrm_pkg::*;
    localparam logic [7:0] HALF = 8'h07;
    localparam logic [7:0] RST = 8'h05;
    localparam logic [3:0] REV = 4'h2; // arbitrary
    localparam logic [27:0] FIXED = 28'h0a5c3e1; // arbitrary
    localparam logic [31:0] ID_ADDR = 32'h01c40028;
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic sys_hold = 1'b1;
    logic debug_en = 1'b0;
    logic [1:0] mode = 2'h0;
    logic tdi = 1'b0;
    logic tms = 1'b0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] addr = 32'h0;
    logic [31:0] rdata;
    logic rvalid, sys_run, test_rst, mode_valid, tdo, tdo_valid;
    jrm_mode_t dev_mode;
    int error_cnt = 0;
    int samples_checked = 0;

    always #2 i_clk = ~i_clk;

    jrm_if link_if();
    jrm_ctl #(.HALF(HALF), .RST_TCKS(RST)) jrm_ctl_i (.i_clk(i_clk),
        .i_rst_n(i_rst_n), .i_ce(1'b1), .link(link_if),
        .i_sys_hold(sys_hold), .i_debug_en(debug_en), .i_mode(mode),
        .i_tms(tms), .i_tdi(tdi), .o_tdo(tdo), .o_tdo_valid(tdo_valid),
        .o_trst_released());
    jrm_dev #(.ID_REV(REV), .ID_FIXED(FIXED)) jrm_dev_i (.i_clk(i_clk),
        .i_rst_n(i_rst_n), .i_ce(1'b1), .link(link_if), .i_rd(rd),
        .i_wr(wr), .i_addr(addr), .o_rdata(rdata), .o_rvalid(rvalid),
        .o_sys_run(sys_run), .o_test_rst(test_rst), .o_mode(dev_mode),
        .o_mode_valid(mode_valid));
    jrm_checker #(.HALF(HALF), .RST_TCKS(RST)) jrm_checker_i (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .sys_rst_n(link_if.sys_rst_n),
        .tck(link_if.tck), .trst_n_o(link_if.trst_n_o),
        .trst_n_oe(link_if.trst_n_oe), .trst_n(link_if.trst_n),
        .mode_select_pins(link_if.mode_select_pins), .tms(link_if.tms),
        .tdi(link_if.tdi), .tdo(link_if.tdo));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic chk1(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask : chk1

    // link pins cross a synchroniser, so allow margin past the rises
    task automatic tcks(input int n);
        repeat (n) @(posedge link_if.tck);
        repeat (12) @(posedge i_clk);
        #1;
    endtask : tcks

    task automatic rd_chk(input logic [31:0] a, input logic w,
                          input logic ev, input logic [31:0] ed);
        rd = 1'b1;
        wr = w;
        addr = a;
        @(posedge i_clk);
        #1;
        rd = 1'b0;
        wr = 1'b0;
        chk1(rvalid, ev);
        chk(rdata, ed);
        @(posedge i_clk);
        #1;
    endtask : rd_chk

    task automatic tdo_wait;
        do begin
            @(posedge i_clk);
            #1;
        end while (tdo_valid !== 1'b1);
    endtask : tdo_wait

    task automatic tdo_chk(input logic e);
        tdo_wait;
        chk1(tdo, e);
    endtask : tdo_chk

    task automatic t_power_up;
        chk1(link_if.sys_rst_n, 1'b0);
        chk1(link_if.trst_n, 1'b0);
        chk1(test_rst, 1'b1);
        chk1(mode_valid, 1'b0);
        $display("test power_up done");
    endtask : t_power_up

    task automatic t_held_sys;
        tcks(8);
        chk1(sys_run, 1'b0);
        rd_chk(ID_ADDR, 1'b0, 1'b1, {4'h0, FIXED});
        debug_en = 1'b1;
        tdi = 1'b1;
        tcks(4);
        chk1(test_rst, 1'b0);
        chk1(mode_valid, 1'b0);
        tdo_chk(1'b1);
        tdi = 1'b0;
        tcks(3);
        tdo_chk(1'b0);
        $display("test held_sys done");
    endtask : t_held_sys

    task automatic t_boot;
        debug_en = 1'b0;
        tcks(3);
        sys_hold = 1'b0;
        tcks(3);
        chk1(sys_run, 1'b1);
        chk1(test_rst, 1'b1);
        chk1(link_if.tdo, 1'b0);
        rd_chk(ID_ADDR, 1'b1, 1'b0, {REV, FIXED});
        rd_chk(ID_ADDR, 1'b0, 1'b1, {REV, FIXED});
        rd_chk(ID_ADDR + 32'h4, 1'b0, 1'b1, 32'h0);
        $display("test boot done");
    endtask : t_boot

    task automatic t_modes;
        for (int m = 0; m < 4; m++) begin
            mode = m[1:0];
            debug_en = 1'b1;
            tcks(3);
            chk1(mode_valid, 1'b1);
            chk1(dev_mode == JRM_BSCAN, m == 3);
            mode = ~m[1:0];
            tcks(3);
            chk1(dev_mode == JRM_BSCAN, m == 3);
            debug_en = 1'b0;
            tcks(3);
            chk1(test_rst, 1'b1);
        end
        $display("test modes done");
    endtask : t_modes

    // one fall with tms high loads the id; the bit shows two falls later
    task automatic t_scan_id;
        logic [31:0] id;
        id = {REV, FIXED};
        mode = 2'h3;
        debug_en = 1'b1;
        tcks(3);
        chk1(dev_mode == JRM_BSCAN, 1'b1);
        tms = 1'b1;
        tdo_wait;
        tms = 1'b0;
        tdo_wait;
        for (int i = 0; i < 32; i++) begin
            tdo_chk(id[i]);
        end
        $display("test scan_id done");
    endtask : t_scan_id

    task automatic test_done;
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : test_done

    initial begin
        repeat (20) @(posedge i_clk);
        #1;
        i_rst_n = 1'b1;
        @(posedge i_clk);
        #1;
        t_power_up;
        t_held_sys;
        t_boot;
        t_modes;
        t_scan_id;
        test_done;
    end

    // whole run needs about 1400 cycles
    initial begin
        #80000;
        error_cnt++;
        test_done;
    end
endmodule : tb_top
